// File: ldr_regs.svh
// register offsets, fields and reset values of the link diagnostics page
`ifndef LDR_REGS_SVH
`define LDR_REGS_SVH
`define LDR_PAGE_SEL_ADDR 5'h13
`define LDR_PAGE_DIAG 2'h2
`define LDR_LEN_ADDR 5'h14
`define LDR_FREQ_ADDR 5'h15
`define LDR_FREQ_SAMPLE_BIT 15
`define LDR_FREQ_CTL_SEL_BIT 8
`define LDR_LEN_UNKNOWN 8'hFF
`define LDR_RESET_16 16'h0000
`define LDR_RESET_8 8'h00
`define LDR_RESET_2 2'h0
`endif

// File: ldr_pkg.sv
// types shared by the link diagnostics register bank
package ldr_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } ldr_req_s;
  typedef enum logic [0:0] {
    LDR_SEL_OFFSET,
    LDR_SEL_CONTROL
  } ldr_sel_e;
  typedef enum {
    LDR_IDLE,
    LDR_FETCH
  } ldr_state_e;
endpackage

// File: ldr_link_diag.sv
// page two link diagnostics registers: cable length and frequency offset sample
// Behaviour
// - diagnostics registers answer only while page selector low bits equal binary 10
// - cable length valid only at 100 Mb with link up
// - cable length reported in metres, read-only, bits 7:0
// - no estimate available gives code FF
// - reserved bits ignore writes and read as zero
// - sample request with select zero fetches long-term frequency offset
// - sample request with select one fetches frequency control value
// - sample request bit always reads zero
// - result field loads only after a sample request
// - result is eight-bit two's complement, about 5.1562 ppm a step
// - codes run 0x80 most negative, 0x00 zero, 0x7F most positive
`timescale 1ns/1ns
`include "ldr_regs.svh"
module ldr_link_diag import ldr_pkg::*; (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  // management register access
  input wire ldr_req_s REQ,
  output logic [15:0] RDATA,
  output logic RVALID,
  // status from the 100 Mb receive path (same clock)
  input wire logic SPEED_100,
  input wire logic LINK_OK,
  input wire logic LEN_VALID,
  input wire logic [7:0] LEN_EST,
  // dsp sample port
  output logic DSP_REQ,
  output logic DSP_SEL,
  input wire logic DSP_ACK,
  input wire logic [7:0] DSP_VALUE
);
  logic [1:0] page_ff;
  logic ctl_sel_ff;
  logic [7:0] freq_ff;
  logic [7:0] len_ff;
  ldr_state_e state_ff;
  logic on_page;
  logic wr_freq;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
    hit = (a == target);
  endfunction

  assign on_page = (page_ff == `LDR_PAGE_DIAG);
  assign wr_freq = REQ.wr && on_page && hit(REQ.addr, `LDR_FREQ_ADDR);

  // page selector is always visible
  always_ff @(posedge CLK) begin
    if (SRST) begin
      page_ff <= `LDR_RESET_2;
    end else if (CE && REQ.wr && hit(REQ.addr, `LDR_PAGE_SEL_ADDR)) begin
      page_ff <= REQ.wdata[1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctl_sel_ff <= 1'h0;
    end else if (CE && wr_freq) begin
      ctl_sel_ff <= REQ.wdata[`LDR_FREQ_CTL_SEL_BIT];
    end
  end

  // cable length tracked continuously; unknown unless 100 Mb with link
  always_ff @(posedge CLK) begin
    if (SRST) begin
      len_ff <= `LDR_RESET_8;
    end else if (CE) begin
      if (SPEED_100 && LINK_OK && LEN_VALID) begin
        len_ff <= LEN_EST;
      end else begin
        len_ff <= `LDR_LEN_UNKNOWN;
      end
    end
  end

  // sample handshake; a request during a fetch is ignored
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_ff <= LDR_IDLE;
      DSP_REQ <= 1'b0;
      DSP_SEL <= 1'b0;
      freq_ff <= `LDR_RESET_8;
    end else if (CE) begin
      case (state_ff)
        LDR_IDLE: begin
          if (wr_freq && REQ.wdata[`LDR_FREQ_SAMPLE_BIT]) begin
            state_ff <= LDR_FETCH;
            DSP_REQ <= 1'b1;
            // select as written in the same access
            DSP_SEL <= REQ.wdata[`LDR_FREQ_CTL_SEL_BIT];
          end
        end
        LDR_FETCH: begin
          if (DSP_ACK) begin
            freq_ff <= DSP_VALUE;
            DSP_REQ <= 1'b0;
            state_ff <= LDR_IDLE;
          end
        end
        default: state_ff <= LDR_IDLE;
      endcase
    end
  end

  // read port, one cycle after the read strobe
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RDATA <= `LDR_RESET_16;
      RVALID <= 1'b0;
    end else if (CE) begin
      RVALID <= REQ.rd;
      RDATA <= `LDR_RESET_16;
      if (REQ.rd) begin
        if (hit(REQ.addr, `LDR_PAGE_SEL_ADDR)) begin
          RDATA <= {14'h0000, page_ff};
        end else if (on_page && hit(REQ.addr, `LDR_LEN_ADDR)) begin
          RDATA <= {8'h00, len_ff};
        end else if (on_page && hit(REQ.addr, `LDR_FREQ_ADDR)) begin
          RDATA <= {1'h0, 6'h00, ctl_sel_ff, freq_ff};
        end
      end
    end
  end

  // read path checks
  AST_SAMPLE_READS_ZERO: assert property (@(posedge CLK) disable iff (SRST)
    RVALID |-> !RDATA[15]) else $error("sample bit read back as one");

  AST_LEN_RES_ZERO: assert property (@(posedge CLK) disable iff (SRST)
    RVALID |-> RDATA[14:9] == 6'h00) else $error("reserved bits nonzero");

  AST_LEN_UPPER_ZERO: assert property (@(posedge CLK) disable iff (SRST)
    (CE && REQ.rd && on_page && hit(REQ.addr, `LDR_LEN_ADDR)) |=> RDATA[15:8] == 8'h00)
    else $error("length upper byte nonzero");

  AST_LEN_READ: assert property (@(posedge CLK) disable iff (SRST)
    (CE && REQ.rd && on_page && hit(REQ.addr, `LDR_LEN_ADDR)) |=> RDATA[7:0] == $past(len_ff))
    else $error("length read wrong");

  AST_FREQ_READ: assert property (@(posedge CLK) disable iff (SRST)
    (CE && REQ.rd && on_page && hit(REQ.addr, `LDR_FREQ_ADDR))
    |=> RDATA[7:0] == $past(freq_ff) && RDATA[8] == $past(ctl_sel_ff)) else $error("freq read wrong");

  AST_RVALID: assert property (@(posedge CLK) disable iff (SRST)
    CE |=> RVALID == $past(REQ.rd)) else $error("read answer misplaced");

  AST_IDLE_RDATA_ZERO: assert property (@(posedge CLK) disable iff (SRST)
    (CE && !REQ.rd) |=> RDATA == 16'h0000 && !RVALID) else $error("data without read");

  AST_WRITE_NO_ANSWER: assert property (@(posedge CLK) disable iff (SRST)
    (CE && REQ.wr) |=> !RVALID) else $error("write answered");

  AST_UNMAPPED_ZERO: assert property (@(posedge CLK) disable iff (SRST)
    (CE && REQ.rd && !hit(REQ.addr, `LDR_PAGE_SEL_ADDR) && !hit(REQ.addr, `LDR_LEN_ADDR)
    && !hit(REQ.addr, `LDR_FREQ_ADDR)) |=> RDATA == 16'h0000) else $error("unmapped nonzero");

  // page selector checks
  AST_PAGE: assert property (@(posedge CLK) disable iff (SRST)
    (CE && REQ.rd && !on_page && REQ.addr != `LDR_PAGE_SEL_ADDR) |=> RDATA == 16'h0000)
    else $error("visible off page");

  AST_PAGE_LEN_HIDDEN: assert property (@(posedge CLK) disable iff (SRST)
    (CE && REQ.rd && !on_page && hit(REQ.addr, `LDR_LEN_ADDR)) |=> RDATA == 16'h0000)
    else $error("length visible off page");

  AST_PAGE_READ: assert property (@(posedge CLK) disable iff (SRST)
    (CE && REQ.rd && hit(REQ.addr, `LDR_PAGE_SEL_ADDR)) |=> RDATA == {14'h0000, $past(page_ff)})
    else $error("page read wrong");

  AST_PAGE_WRITE: assert property (@(posedge CLK) disable iff (SRST)
    (CE && REQ.wr && hit(REQ.addr, `LDR_PAGE_SEL_ADDR)) |=> page_ff == $past(REQ.wdata[1:0]))
    else $error("page not written");

  AST_PAGE_HOLD: assert property (@(posedge CLK) disable iff (SRST)
    !(CE && REQ.wr && hit(REQ.addr, `LDR_PAGE_SEL_ADDR)) |=> $stable(page_ff))
    else $error("page changed");

  // sample handshake checks
  AST_HOLD: assert property (@(posedge CLK) disable iff (SRST)
    !(state_ff == LDR_FETCH && DSP_ACK && CE) |=> $stable(freq_ff))
    else $error("result changed without sample");

  AST_LOAD: assert property (@(posedge CLK) disable iff (SRST)
    (CE && state_ff == LDR_FETCH && DSP_ACK) |=> freq_ff == $past(DSP_VALUE))
    else $error("sample not loaded");

  AST_OFFSET_LOAD: assert property (@(posedge CLK) disable iff (SRST)
    (CE && state_ff == LDR_FETCH && DSP_ACK && !DSP_SEL) |=> freq_ff == $past(DSP_VALUE))
    else $error("offset not loaded");

  AST_CONTROL_LOAD: assert property (@(posedge CLK) disable iff (SRST)
    (CE && state_ff == LDR_FETCH && DSP_ACK && DSP_SEL) |=> freq_ff == $past(DSP_VALUE))
    else $error("control value not loaded");

  AST_SEL: assert property (@(posedge CLK) disable iff (SRST)
    (CE && state_ff == LDR_IDLE && wr_freq && REQ.wdata[15])
    |=> DSP_REQ && DSP_SEL == $past(REQ.wdata[8])) else $error("wrong select");

  AST_OFFSET_SEL: assert property (@(posedge CLK) disable iff (SRST)
    (CE && state_ff == LDR_IDLE && wr_freq && REQ.wdata[15] && !REQ.wdata[8])
    |=> DSP_REQ && !DSP_SEL) else $error("offset not selected");

  AST_SEL_STORE: assert property (@(posedge CLK) disable iff (SRST)
    (CE && wr_freq) |=> ctl_sel_ff == $past(REQ.wdata[8])) else $error("select not stored");

  AST_SEL_HOLD: assert property (@(posedge CLK) disable iff (SRST)
    !(CE && wr_freq) |=> $stable(ctl_sel_ff)) else $error("select changed");

  AST_NO_TRIGGER: assert property (@(posedge CLK) disable iff (SRST)
    (CE && state_ff == LDR_IDLE && !(wr_freq && REQ.wdata[15])) |=> !DSP_REQ)
    else $error("fetch without request");

  AST_REQ_HOLD: assert property (@(posedge CLK) disable iff (SRST)
    (CE && state_ff == LDR_FETCH && !DSP_ACK) |=> DSP_REQ && state_ff == LDR_FETCH)
    else $error("request dropped early");

  AST_REQ_DROP: assert property (@(posedge CLK) disable iff (SRST)
    (CE && state_ff == LDR_FETCH && DSP_ACK) |=> !DSP_REQ && state_ff == LDR_IDLE)
    else $error("request not dropped");

  AST_SEL_STABLE_FETCH: assert property (@(posedge CLK) disable iff (SRST)
    (CE && state_ff == LDR_FETCH) |=> $stable(DSP_SEL)) else $error("select moved in fetch");

  AST_REQ_STATE: assert property (@(posedge CLK) disable iff (SRST)
    DSP_REQ == (state_ff == LDR_FETCH)) else $error("request and state disagree");

  // length tracking checks
  AST_LEN_UNKNOWN: assert property (@(posedge CLK) disable iff (SRST)
    (CE && !(SPEED_100 && LINK_OK)) |=> len_ff == 8'hFF) else $error("length not FF");

  AST_LEN_INVALID: assert property (@(posedge CLK) disable iff (SRST)
    (CE && !LEN_VALID) |=> len_ff == `LDR_LEN_UNKNOWN) else $error("invalid length shown");

  AST_LINK_DOWN: assert property (@(posedge CLK) disable iff (SRST)
    (CE && !LINK_OK) |=> len_ff == `LDR_LEN_UNKNOWN) else $error("length shown without link");

  AST_SPEED_LOW: assert property (@(posedge CLK) disable iff (SRST)
    (CE && !SPEED_100) |=> len_ff == `LDR_LEN_UNKNOWN) else $error("length shown off 100 Mb");

  AST_LEN_TRACK: assert property (@(posedge CLK) disable iff (SRST)
    (CE && SPEED_100 && LINK_OK && LEN_VALID) |=> len_ff == $past(LEN_EST))
    else $error("length not loaded");

  // clock enable and reset checks
  AST_CE_FREEZE_LEN: assert property (@(posedge CLK) disable iff (SRST)
    !CE |=> $stable(len_ff)) else $error("length moved while frozen");

  AST_CE_FREEZE_FSM: assert property (@(posedge CLK) disable iff (SRST)
    !CE |=> $stable(state_ff) && $stable(DSP_REQ)) else $error("handshake moved while frozen");

  AST_CE_FREEZE_READ: assert property (@(posedge CLK) disable iff (SRST)
    !CE |=> $stable(RDATA) && $stable(RVALID)) else $error("read port moved while frozen");

  AST_RESET_OUTPUTS: assert property (@(posedge CLK)
    SRST |=> RDATA == 16'h0000 && !RVALID && !DSP_REQ && !DSP_SEL)
    else $error("outputs not cleared by reset");

  AST_RESET_STATE: assert property (@(posedge CLK)
    SRST |=> len_ff == 8'h00 && freq_ff == 8'h00 && page_ff == 2'h0)
    else $error("state not cleared by reset");
endmodule

// File: tb.sv
// self-checking bench for the link diagnostics register bank
`timescale 1ns/1ns
`include "ldr_regs.svh"
module tb import ldr_pkg::*;;
  logic clk = 0, srst = 1, sp = 0, lk = 0, lv = 0, ack = 0, sel, dreq, dsel, rv;
  ldr_req_s req = '0;
  logic [7:0] len = 8'h00, dv = 8'h00;
  logic [15:0] rdata;
  logic [31:0] rnd = 32'h202D;
  logic [15:0] q[$];
  int n_errors = 0, n_tests = 0, cyc = 0;
  always #2 clk = ~clk;
  ldr_link_diag dut (.CLK(clk), .SRST(srst), .CE(1'b1), .REQ(req), .RDATA(rdata), .RVALID(rv),
    .SPEED_100(sp), .LINK_OK(lk), .LEN_VALID(lv), .LEN_EST(len), .DSP_REQ(dreq),
    .DSP_SEL(dsel), .DSP_ACK(ack), .DSP_VALUE(dv));
  function automatic [31:0] lfsr(input [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string name, input [15:0] seen, input [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // a read carries its expected word in wdata and notes it for the monitor
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{w, ~w, a, d};
    if (!w) q.push_back(d);
    @(posedge clk) req <= '0;
  endtask
  // dsp answers one cycle late, then shows a changing value
  always @(posedge clk) begin
    ack <= dreq & ~ack;
    if (dreq && !ack) check("dsel", {15'h0000, dsel}, {15'h0000, sel});
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      wrap_up;
    end
    if (rv) check("rdata", rdata, q.size() != 0 ? q.pop_front() : ~rdata);
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 0;
    acc(0, `LDR_PAGE_SEL_ADDR, 16'h0000);
    acc(0, `LDR_LEN_ADDR, 16'h0000);
    acc(1, `LDR_PAGE_SEL_ADDR, 16'h0002);
    acc(0, `LDR_PAGE_SEL_ADDR, 16'h0002);
    acc(0, `LDR_LEN_ADDR, 16'h00FF);
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      {sp, lk, lv} <= (i < 3) ? 3'h7 : rnd[2:0];
      len <= rnd[15:8];
      acc(1, `LDR_LEN_ADDR, 16'hFFFF);
      acc(0, `LDR_LEN_ADDR, {8'h00, (i < 3 || &rnd[2:0]) ? rnd[15:8] : 8'hFF});
    end
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      sel = i[0];
      dv <= rnd[7:0];
      acc(1, `LDR_FREQ_ADDR, {1'b1, rnd[14:9], sel, rnd[23:16]});
      repeat (5) @(posedge clk);
      dv <= ~rnd[7:0];
      acc(0, `LDR_FREQ_ADDR, {7'h00, sel, rnd[7:0]});
      acc(1, `LDR_FREQ_ADDR, {7'h00, ~sel, 8'h00});
      repeat (5) @(posedge clk);
      acc(0, `LDR_FREQ_ADDR, {7'h00, ~sel, rnd[7:0]});
    end
    acc(1, `LDR_PAGE_SEL_ADDR, 16'h0001);
    acc(0, `LDR_FREQ_ADDR, 16'h0000);
    repeat (4) @(posedge clk);
    wrap_up;
  end
endmodule
